// file: core/crf_regs.sv
// Purpose: programmer-visible cpu register set with address forming
// Assumes: sequencer issues one command per cycle on cmd; memory read
//          data arrives in cmd.data; registers sit on no bus
// Notes:   accumulator and low index byte are not touched by reset
`timescale 1ns/1ps
module crf_regs
	import crf_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// sequencer command
	input  wire crf_cmd_s    cmd,
	// memory access request
	output logic      [15:0] mem_addr,
	output logic      [7:0]  mem_wdata,
	output logic             mem_rd,
	output logic             mem_wr,
	// register view and status
	output crf_view_s        regs,
	output logic             div_error,
	output logic             vec_done
);
	typedef struct packed {
		crf_state_e  state;
		logic [7:0]  acc;
		logic [7:0]  idx_hi;
		logic [7:0]  idx_lo;
		logic [15:0] sp;
		logic [15:0] pc;
		logic [7:0]  ccr;
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        rd;
		logic        wr;
		logic        div_err;
		logic        vdone;
	} crf_state_s;

	crf_state_s st_r;
	crf_state_s st_nxt;

	logic [7:0] alu_a;
	logic [7:0] alu_res;
	logic       f_v;
	logic       f_h;
	logic       f_n;
	logic       f_z;
	logic       f_c;

	function automatic logic [15:0] crf_sext8(input logic [7:0] v);
		crf_sext8 = {{8{v[7]}}, v};
	endfunction

	function automatic logic [7:0] crf_fix_cc(input logic [7:0] cc);
		crf_fix_cc = cc | CRF_CC_FIXED;
	endfunction

	// h:x joined as one pointer, shared by the indexed address forms
	function automatic logic [15:0] crf_hx(input logic [7:0] hi, input logic [7:0] lo);
		crf_hx = {hi, lo};
	endfunction

	// wraps at the top of the 64k space, as the pointer registers do
	function automatic logic [15:0] crf_up16(input logic [15:0] v);
		crf_up16 = v + CRF_ONE16;
	endfunction

	// operand for alu comes from accumulator or low index byte
	assign alu_a = (cmd.op == CRF_OP_ALU_X) ? st_r.idx_lo : st_r.acc;

	crf_alu u_alu (
		.op_a     (alu_a),
		.op_b     (cmd.data),
		.carry_in (st_r.ccr[CRF_CC_C]),
		.func     (cmd.alu),
		.result   (alu_res),
		.flag_v   (f_v),
		.flag_h   (f_h),
		.flag_n   (f_n),
		.flag_z   (f_z),
		.flag_c   (f_c)
	);

	always_comb
	begin
		logic [15:0] prod;
		logic [15:0] dividend;
		logic [15:0] quot;
		logic [7:0]  cc;
		prod     = 16'h0000;
		dividend = 16'h0000;
		quot     = 16'h0000;
		st_nxt   = st_r;
		st_nxt.rd = 1'b0;
		st_nxt.wr = 1'b0;
		cc = st_r.ccr;
		case (st_r.state)
			CRF_ST_VHI:
			begin
				// vector high byte arrives in the same cycle as its read request
				st_nxt.addr = CRF_VEC_LO;
				st_nxt.rd   = 1'b1;
				st_nxt.pc   = {cmd.data, st_r.pc[7:0]};
				st_nxt.state = CRF_ST_VLO;
			end
			CRF_ST_VLO:
			begin
				st_nxt.pc    = {st_r.pc[15:8], cmd.data};
				st_nxt.state = CRF_ST_RUN;
				st_nxt.vdone = 1'b1;
			end
			CRF_ST_RUN:
			begin
				case (cmd.op)
					CRF_OP_ALU_A, CRF_OP_ALU_X:
					begin
						if (cmd.op == CRF_OP_ALU_A)
							st_nxt.acc = alu_res;
						else
							st_nxt.idx_lo = alu_res;
						if (cmd.ld_v)
							cc[CRF_CC_V] = f_v;
						if (cmd.ld_h)
							cc[CRF_CC_H] = f_h;
						if (cmd.ld_nzc)
						begin
							cc[CRF_CC_N] = f_n;
							cc[CRF_CC_Z] = f_z;
							cc[CRF_CC_C] = f_c;
						end
					end
					CRF_OP_LDA:  st_nxt.acc = cmd.data;
					CRF_OP_LDX:  st_nxt.idx_lo = cmd.data;
					CRF_OP_LDH:  st_nxt.idx_hi = cmd.data;
					CRF_OP_LDHX: {st_nxt.idx_hi, st_nxt.idx_lo} = cmd.word;
					CRF_OP_TAX:  st_nxt.idx_lo = st_r.acc;
					CRF_OP_TXA:  st_nxt.acc = st_r.idx_lo;
					CRF_OP_LDSP: st_nxt.sp = cmd.word;
					CRF_OP_STACK_ADJUST_INSTR:
						st_nxt.sp = st_r.sp + crf_sext8(cmd.data);
					CRF_OP_STACK_LOW_RESET_INSTR:
						st_nxt.sp = {st_r.sp[15:8], CRF_SP_LO_INIT};
					CRF_OP_PUSH:
					begin
						// data byte is chosen by the sequencer: pc bytes, a, x, h or ccr
						st_nxt.addr  = st_r.sp;
						st_nxt.wdata = cmd.data;
						st_nxt.wr    = 1'b1;
						st_nxt.sp    = st_r.sp - CRF_ONE16;
					end
					CRF_OP_PULL:
					begin
						st_nxt.sp   = crf_up16(st_r.sp);
						st_nxt.addr = crf_up16(st_r.sp);
						st_nxt.rd   = 1'b1;
					end
					CRF_OP_MUL:
					begin
						prod = {8'h00, st_r.idx_lo} * {8'h00, st_r.acc};
						st_nxt.idx_lo = prod[15:8];
						st_nxt.acc    = prod[7:0];
						cc[CRF_CC_H]  = 1'b0;
						cc[CRF_CC_C]  = 1'b0;
					end
					CRF_OP_DIV:
					begin
						// h:a divided by x; quotient in a, remainder in h
						dividend = {st_r.idx_hi, st_r.acc};
						if (st_r.idx_lo == CRF_ZERO8)
						begin
							st_nxt.div_err = 1'b1;
							cc[CRF_CC_C]   = 1'b1;
						end
						else
						begin
							quot = dividend / {8'h00, st_r.idx_lo};
							st_nxt.div_err = 1'b0;
							st_nxt.acc    = quot[7:0];
							st_nxt.idx_hi = 8'(dividend % {8'h00, st_r.idx_lo});
							cc[CRF_CC_C]  = (quot[15:8] != CRF_ZERO8);
							cc[CRF_CC_Z]  = (quot[7:0] == CRF_ZERO8);
						end
					end
					CRF_OP_BRANCH: st_nxt.pc = st_r.pc + crf_sext8(cmd.data);
					CRF_OP_JUMP:   st_nxt.pc = cmd.word;
					CRF_OP_PC_INC: st_nxt.pc = crf_up16(st_r.pc);
					CRF_OP_LDCC:   cc = cmd.data;
					default:       st_nxt.rd = 1'b0;
				endcase
				// address generator request, full 16-bit linear space
				if (cmd.op == CRF_OP_NOP)
				begin
					st_nxt.rd = 1'b1;
					case (cmd.adsel)
						CRF_AD_DIR:  st_nxt.addr = {CRF_ZERO8, cmd.data};
						CRF_AD_EXT:  st_nxt.addr = cmd.word;
						CRF_AD_IDX:  st_nxt.addr = crf_hx(st_r.idx_hi, st_r.idx_lo);
						CRF_AD_IDXO:
							st_nxt.addr = crf_hx(st_r.idx_hi, st_r.idx_lo) + cmd.offset;
						CRF_AD_SP:   st_nxt.addr = crf_up16(st_r.sp);
						CRF_AD_SPO:  st_nxt.addr = st_r.sp + cmd.offset;
						default:     st_nxt.addr = st_r.pc;
					endcase
				end
			end
			default:
			begin
				st_nxt.state = CRF_ST_RUN;
				st_nxt.vdone = 1'b1;
			end
		endcase
		st_nxt.ccr = crf_fix_cc(cc);
		if (!rst_n)
		begin
			st_nxt.state  = CRF_ST_VHI;
			st_nxt.idx_hi = CRF_HI_RESET;
			st_nxt.sp     = CRF_SP_RESET;
			st_nxt.pc     = CRF_PC_RESET;
			st_nxt.ccr    = crf_fix_cc(CRF_ZERO8) | (CRF_ONE8 << CRF_CC_I);
			st_nxt.addr   = CRF_VEC_HI;
			st_nxt.wdata  = CRF_ZERO8;
			st_nxt.rd     = 1'b1;
			st_nxt.wr     = 1'b0;
			st_nxt.div_err = 1'b0;
			st_nxt.vdone  = 1'b0;
			// acc and idx_lo deliberately keep their value
			st_nxt.acc    = st_r.acc;
			st_nxt.idx_lo = st_r.idx_lo;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		st_r <= st_nxt;
	end

	// view only; no address decode exists for these registers
	// one driver for the whole view, fields in crf_view_s order
	assign regs      = {st_r.acc, st_r.idx_hi, st_r.idx_lo, st_r.sp, st_r.pc, st_r.ccr};
	assign mem_addr  = st_r.addr;
	assign mem_wdata = st_r.wdata;
	assign mem_rd    = st_r.rd;
	assign mem_wr    = st_r.wr;
	assign div_error = st_r.div_err;
	assign vec_done  = st_r.vdone;

endmodule

// file: core/crf_pkg.sv
// Purpose: shared constants and types for the cpu register set
// Assumes: 8-bit data, 16-bit address space
// Notes:   operation codes are driven by the instruction sequencer
package crf_pkg;

	localparam int unsigned CRF_DW = 8;
	localparam int unsigned CRF_AW = 16;

	localparam logic [7:0]  CRF_HI_RESET   = 8'h00;
	localparam logic [15:0] CRF_SP_RESET   = 16'h00FF;
	localparam logic [7:0]  CRF_SP_LO_INIT = 8'hFF;
	localparam logic [15:0] CRF_PC_RESET   = 16'h0000;
	localparam logic [15:0] CRF_VEC_HI     = 16'hFFFE;
	localparam logic [15:0] CRF_VEC_LO     = 16'hFFFF;
	localparam logic [15:0] CRF_DIR_LIMIT  = 16'h00FF;
	localparam logic [7:0]  CRF_ZERO8      = 8'h00;
	localparam logic [15:0] CRF_ONE16      = 16'h0001;
	localparam logic [15:0] CRF_ZERO16     = 16'h0000;
	localparam logic [7:0]  CRF_ONE8       = 8'h01;

	// condition code bit positions
	localparam int unsigned CRF_CC_V = 7;
	localparam int unsigned CRF_CC_S6 = 6;
	localparam int unsigned CRF_CC_S5 = 5;
	localparam int unsigned CRF_CC_H = 4;
	localparam int unsigned CRF_CC_I = 3;
	localparam int unsigned CRF_CC_N = 2;
	localparam int unsigned CRF_CC_Z = 1;
	localparam int unsigned CRF_CC_C = 0;
	localparam logic [7:0]  CRF_CC_FIXED = 8'h60;

	// alu operations
	typedef enum logic [3:0] {
		CRF_ALU_ADD = 4'h0,
		CRF_ALU_ADC = 4'h1,
		CRF_ALU_SUB = 4'h2,
		CRF_ALU_AND = 4'h3,
		CRF_ALU_OR  = 4'h4,
		CRF_ALU_XOR = 4'h5,
		CRF_ALU_CLR = 4'h6,
		CRF_ALU_INC = 4'h7,
		CRF_ALU_DEC = 4'h8,
		CRF_ALU_COM = 4'h9,
		CRF_ALU_NEG = 4'hA,
		CRF_ALU_LSL = 4'hB,
		CRF_ALU_LSR = 4'hC,
		CRF_ALU_ROL = 4'hD,
		CRF_ALU_ROR = 4'hE,
		CRF_ALU_PASS = 4'hF
	} crf_alu_e;

	// register-level operations from the sequencer
	typedef enum logic [4:0] {
		CRF_OP_NOP      = 5'h00,
		CRF_OP_ALU_A    = 5'h01,
		CRF_OP_ALU_X    = 5'h02,
		CRF_OP_LDA      = 5'h03,
		CRF_OP_LDX      = 5'h04,
		CRF_OP_LDH      = 5'h05,
		CRF_OP_LDHX     = 5'h06,
		CRF_OP_TAX      = 5'h07,
		CRF_OP_TXA      = 5'h08,
		CRF_OP_LDSP     = 5'h09,
		CRF_OP_STACK_ADJUST_INSTR = 5'h0A,
		CRF_OP_STACK_LOW_RESET_INSTR = 5'h0B,
		CRF_OP_PUSH     = 5'h0C,
		CRF_OP_PULL     = 5'h0D,
		CRF_OP_MUL      = 5'h0E,
		CRF_OP_DIV      = 5'h0F,
		CRF_OP_BRANCH   = 5'h10,
		CRF_OP_JUMP     = 5'h11,
		CRF_OP_PC_INC   = 5'h12,
		CRF_OP_LDCC     = 5'h13
	} crf_op_e;

	// address source for the address generator
	typedef enum logic [2:0] {
		CRF_AD_PC   = 3'h0,
		CRF_AD_DIR  = 3'h1,
		CRF_AD_EXT  = 3'h2,
		CRF_AD_IDX  = 3'h3,
		CRF_AD_IDXO = 3'h4,
		CRF_AD_SP   = 3'h5,
		CRF_AD_SPO  = 3'h6
	} crf_adsel_e;

	// reset vector fetch states
	typedef enum logic [2:0] {
		CRF_ST_VHI = 3'b001,
		CRF_ST_VLO = 3'b010,
		CRF_ST_RUN = 3'b100
	} crf_state_e;

	typedef struct packed {
		crf_op_e          op;
		crf_alu_e         alu;
		logic [7:0]       data;
		logic [15:0]      word;
		logic [15:0]      offset;
		crf_adsel_e       adsel;
		logic             ld_v;
		logic             ld_h;
		logic             ld_nzc;
	} crf_cmd_s;

	typedef struct packed {
		logic [7:0]  acc;
		logic [7:0]  idx_hi;
		logic [7:0]  idx_lo;
		logic [15:0] sp;
		logic [15:0] pc;
		logic [7:0]  ccr;
	} crf_view_s;

endpackage

// file: core/crf_alu.sv
// Purpose: 8-bit alu with condition code outputs
// Assumes: purely combinational, same clock domain as caller
// Notes:   half-carry only meaningful for add forms
`timescale 1ns/1ps
module crf_alu
	import crf_pkg::*;
(
	// operands
	input  wire logic [7:0] op_a,
	input  wire logic [7:0] op_b,
	input  wire logic       carry_in,
	input  wire crf_alu_e   func,
	// result
	output logic      [7:0] result,
	output logic            flag_v,
	output logic            flag_h,
	output logic            flag_n,
	output logic            flag_z,
	output logic            flag_c
);
	logic [8:0] sum;
	logic [4:0] low;

	always_comb
	begin
		sum    = {1'b0, op_a};
		low    = 5'h00;
		flag_v = 1'b0;
		flag_h = 1'b0;
		flag_c = carry_in;
		case (func)
			CRF_ALU_ADD, CRF_ALU_ADC:
			begin
				sum    = {1'b0, op_a} + {1'b0, op_b} + {8'h00, (func == CRF_ALU_ADC) & carry_in};
				low    = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]}
					+ {4'h0, (func == CRF_ALU_ADC) & carry_in};
				flag_h = low[4];
				flag_c = sum[8];
				flag_v = (op_a[7] == op_b[7]) & (sum[7] != op_a[7]);
			end
			CRF_ALU_SUB:
			begin
				sum    = {1'b0, op_a} - {1'b0, op_b};
				flag_c = sum[8];
				flag_v = (op_a[7] != op_b[7]) & (sum[7] != op_a[7]);
			end
			CRF_ALU_AND:  sum = {1'b0, op_a & op_b};
			CRF_ALU_OR:   sum = {1'b0, op_a | op_b};
			CRF_ALU_XOR:  sum = {1'b0, op_a ^ op_b};
			CRF_ALU_CLR:  sum = 9'h000;
			CRF_ALU_INC:
			begin
				sum    = {1'b0, op_a} + 9'h001;
				flag_v = (op_a == 8'h7F);
			end
			CRF_ALU_DEC:
			begin
				sum    = {1'b0, op_a} - 9'h001;
				flag_v = (op_a == 8'h80);
			end
			CRF_ALU_COM:
			begin
				sum    = {1'b0, ~op_a};
				flag_c = 1'b1;
			end
			CRF_ALU_NEG:
			begin
				sum    = 9'h000 - {1'b0, op_a};
				flag_c = (op_a != 8'h00);
				flag_v = (op_a == 8'h80);
			end
			CRF_ALU_LSL:
			begin
				sum    = {op_a, 1'b0};
				flag_c = op_a[7];
				flag_v = op_a[7] ^ op_a[6];
			end
			CRF_ALU_LSR:
			begin
				sum    = {2'b00, op_a[7:1]};
				flag_c = op_a[0];
				flag_v = op_a[0];
			end
			CRF_ALU_ROL:
			begin
				sum    = {op_a, carry_in};
				flag_c = op_a[7];
				flag_v = op_a[7] ^ op_a[6];
			end
			CRF_ALU_ROR:
			begin
				sum    = {1'b0, carry_in, op_a[7:1]};
				flag_c = op_a[0];
				flag_v = carry_in ^ op_a[0];
			end
			default:      sum = {1'b0, op_b};
		endcase
		result = sum[7:0];
		flag_n = sum[7];
		flag_z = (sum[7:0] == 8'h00);
	end

endmodule

// file: sim/crf_regs_checker.sv
// Purpose: port-level assertions for the cpu register set
// Assumes: one clock domain, synchronous active-low reset
// Notes:   reset-hold checks compare with values seen before reset
`timescale 1ns/1ps
module crf_regs_checker
	import crf_pkg::*;
(
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        rst_n,
	// command
	input wire crf_cmd_s    cmd,
	// memory request and view
	input wire logic [15:0] mem_addr,
	input wire logic [7:0]  mem_wdata,
	input wire logic        mem_rd,
	input wire logic        mem_wr,
	input wire crf_view_s   regs,
	input wire logic        div_error,
	input wire logic        vec_done
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic [15:0] keep_r;
	logic        ran_r = 1'b0;
	// frozen while reset is low, so it holds the last running values
	always_ff @(posedge clk_sys)
	begin
		if (rst_n)
		begin
			keep_r <= {regs.acc, regs.idx_lo};
			ran_r  <= ran_r | vec_done;
		end
	end
	sequence s_vec_addr;
		mem_rd && mem_addr == CRF_VEC_HI ##1 mem_rd && mem_addr == CRF_VEC_LO;
	endsequence
	sequence s_vec_load;
		vec_done && regs.pc == {$past(cmd.data, 2), $past(cmd.data)};
	endsequence
	a_vec_fetch: assert property ($rose(rst_n) |-> s_vec_addr ##1 s_vec_load)
		else $error("reset vector fetch wrong");
	a_reset_values: assert property ($rose(rst_n) |->
		regs.idx_hi == CRF_HI_RESET && regs.sp == CRF_SP_RESET) else $error("reset values wrong");
	a_reset_keeps: assert property ($rose(rst_n) && ran_r |->
		{regs.acc, regs.idx_lo} == keep_r) else $error("reset changed acc or low index");
	a_ccr_fixed: assert property (vec_done |-> regs.ccr[6:5] == 2'b11)
		else $error("fixed ccr bits not one");
	a_push_order: assert property (vec_done && cmd.op == CRF_OP_PUSH |=> mem_wr &&
		mem_addr == $past(regs.sp) && mem_wdata == $past(cmd.data) &&
		regs.sp == $past(regs.sp) - 16'h0001) else $error("push order wrong");
	a_pull_order: assert property (vec_done && cmd.op == CRF_OP_PULL |=> mem_rd &&
		regs.sp == $past(regs.sp) + 16'h0001 && mem_addr == regs.sp) else $error("pull wrong");
	a_sp_adjust: assert property (vec_done && cmd.op == CRF_OP_STACK_ADJUST_INSTR |=>
		regs.sp == $past(regs.sp) + {{8{$past(cmd.data[7])}}, $past(cmd.data)})
		else $error("stack adjust wrong");
	a_sp_low_reset: assert property (vec_done && cmd.op == CRF_OP_STACK_LOW_RESET_INSTR |=>
		regs.sp == {$past(regs.sp[15:8]), 8'hFF}) else $error("stack low reset wrong");
	a_index_addr: assert property (vec_done && cmd.op == CRF_OP_NOP &&
		cmd.adsel == CRF_AD_IDX |=> mem_rd && mem_addr == {$past(regs.idx_hi), $past(regs.idx_lo)})
		else $error("indexed address wrong");
	a_direct_addr: assert property (vec_done && cmd.op == CRF_OP_NOP &&
		cmd.adsel == CRF_AD_DIR |=> mem_rd && mem_addr == {8'h00, $past(cmd.data)})
		else $error("direct address wrong");
	a_transfer: assert property (vec_done && cmd.op == CRF_OP_TAX |=>
		regs.idx_lo == $past(regs.acc)) else $error("transfer wrong");
	a_branch_rel: assert property (vec_done && cmd.op == CRF_OP_BRANCH |=>
		regs.pc == $past(regs.pc) + {{8{$past(cmd.data[7])}}, $past(cmd.data)})
		else $error("branch target wrong");
	a_mul_result: assert property (vec_done && cmd.op == CRF_OP_MUL |=>
		{regs.idx_lo, regs.acc} == $past(regs.idx_lo) * $past(regs.acc)) else $error("mul wrong");
endmodule
bind crf_regs crf_regs_checker i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .cmd(cmd),
	.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr),
	.regs(regs), .div_error(div_error), .vec_done(vec_done));

// file: sim/crf_mem_model.sv
// Purpose: memory seen by the register set, holding the reset vector
// Assumes: read data is wanted in the cycle the read strobe is high
// Notes:   idle read data flips each cycle so a stale byte never passes
`timescale 1ns/1ps
module crf_mem_model
	import crf_pkg::*;
#(
	parameter logic [15:0] VEC = 16'h4010
)
(
	// clock
	input  wire logic        clk_sys,
	// memory request
	input  wire logic [15:0] mem_addr,
	input  wire logic [7:0]  mem_wdata,
	input  wire logic        mem_rd,
	input  wire logic        mem_wr,
	// read data
	output logic      [7:0]  rd_data
);
	logic [7:0] mem [0:65535];
	logic [7:0] junk_r = 8'hA5;
	initial
	begin
		mem[CRF_VEC_HI] = VEC[15:8];
		mem[CRF_VEC_LO] = VEC[7:0];
	end
	always @(posedge clk_sys)
	begin
		junk_r <= ~junk_r;
		if (mem_wr)
			mem[mem_addr] <= mem_wdata;
	end
	assign rd_data = mem_rd ? mem[mem_addr] : junk_r;
endmodule

// file: sim/cpu8_register_file_tb_top.sv
// Purpose: self-checking bench for the cpu register set
// Assumes: memory model answers reads in the strobe cycle
// Notes:   acc and low index are loaded before the table rows run
`timescale 1ns/1ps
module cpu8_register_file_tb_top
	import crf_pkg::*;
;
	typedef struct packed {
		crf_op_e     op;
		crf_alu_e    fn;
		logic [15:0] w;
		logic [39:0] ex;
	} crf_row_s;
	localparam logic [15:0] VEC = 16'h4010;
	logic        clk_sys = 1'b0;
	logic        rst_n   = 1'b0;
	crf_cmd_s    cmd     = '0;
	logic [15:0] mem_addr;
	logic [7:0]  mem_wdata;
	logic        mem_rd;
	logic        mem_wr;
	crf_view_s   regs;
	logic        div_error;
	logic        vec_done;
	logic [7:0]  rd_data;
	int          err_count = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	// expected {acc, idx_hi, idx_lo, sp} after each row
	crf_row_s    rows [0:20] = '{
		'{CRF_OP_TAX, CRF_ALU_PASS, 16'h0000, 40'h5A125A00FF},
		'{CRF_OP_LDA, CRF_ALU_PASS, 16'h00A7, 40'hA7125A00FF},
		'{CRF_OP_TXA, CRF_ALU_PASS, 16'h0000, 40'h5A125A00FF},
		'{CRF_OP_ALU_X, CRF_ALU_CLR, 16'h0000, 40'h5A120000FF},
		'{CRF_OP_ALU_X, CRF_ALU_DEC, 16'h0000, 40'h5A12FF00FF},
		'{CRF_OP_ALU_X, CRF_ALU_INC, 16'h0000, 40'h5A120000FF},
		'{CRF_OP_ALU_X, CRF_ALU_COM, 16'h0000, 40'h5A12FF00FF},
		'{CRF_OP_ALU_X, CRF_ALU_NEG, 16'h0000, 40'h5A120100FF},
		'{CRF_OP_LDX, CRF_ALU_PASS, 16'h0081, 40'h5A128100FF},
		'{CRF_OP_ALU_X, CRF_ALU_LSL, 16'h0000, 40'h5A120200FF},
		'{CRF_OP_ALU_X, CRF_ALU_ROL, 16'h0000, 40'h5A120500FF},
		'{CRF_OP_ALU_X, CRF_ALU_ROR, 16'h0000, 40'h5A120200FF},
		'{CRF_OP_ALU_X, CRF_ALU_LSR, 16'h0000, 40'h5A120100FF},
		'{CRF_OP_LDX, CRF_ALU_PASS, 16'h000C, 40'h5A120C00FF},
		'{CRF_OP_MUL, CRF_ALU_PASS, 16'h0000, 40'h38120400FF},
		'{CRF_OP_LDHX, CRF_ALU_PASS, 16'h0107, 40'h38010700FF},
		'{CRF_OP_DIV, CRF_ALU_PASS, 16'h0000, 40'h2C040700FF},
		'{CRF_OP_LDSP, CRF_ALU_PASS, 16'h0180, 40'h2C04070180},
		'{CRF_OP_STACK_ADJUST_INSTR, CRF_ALU_PASS, 16'h007F, 40'h2C040701FF},
		'{CRF_OP_STACK_ADJUST_INSTR, CRF_ALU_PASS, 16'h0080, 40'h2C0407017F},
		'{CRF_OP_STACK_LOW_RESET_INSTR, CRF_ALU_PASS, 16'h0000, 40'h2C040701FF}};

	crf_regs i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cmd(cmd), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .regs(regs),
		.div_error(div_error), .vec_done(vec_done));
	crf_mem_model #(.VEC(VEC)) i_mem (.clk_sys(clk_sys), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .rd_data(rd_data));

	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			err_count++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	// drive at the falling edge, look just after the next rising edge
	task automatic issue(input crf_op_e op, input crf_alu_e fn, input logic [15:0] w,
		input crf_adsel_e ad = CRF_AD_PC);
		@(negedge clk_sys);
		cmd = '{op, fn, w[7:0], w, w, ad, 1'b1, 1'b1, 1'b1};
		@(posedge clk_sys);
		#1;
	endtask

	// vector bytes follow the read strobe back into cmd.data
	task automatic do_reset();
		@(negedge clk_sys);
		rst_n = 1'b0;
		cmd   = '0;
		repeat (4) @(negedge clk_sys);
		rst_n = 1'b1;
		for (int i = 0; i < 8 && vec_done !== 1'b1; i++)
		begin
			cmd.data = rd_data;
			@(negedge clk_sys);
		end
	endtask

	initial
	begin
		do_reset();
		chk({vec_done, regs.idx_hi, regs.sp, regs.pc}, {1'b1, 8'h00, 16'h00FF, VEC}, "reset");
		chk(regs.ccr[6:5], 2'b11, "fixed ccr bits");
		issue(CRF_OP_LDA, CRF_ALU_PASS, 16'h005A);
		issue(CRF_OP_LDHX, CRF_ALU_PASS, 16'h1234);
		chk({regs.acc, regs.idx_hi, regs.idx_lo}, 24'h5A1234, "loads");
		foreach (rows[i])
		begin
			issue(rows[i].op, rows[i].fn, rows[i].w);
			chk({regs.acc, regs.idx_hi, regs.idx_lo, regs.sp}, rows[i].ex, "row");
		end
		issue(CRF_OP_PUSH, CRF_ALU_PASS, 16'h00C3);
		chk({mem_wr, mem_addr, mem_wdata, regs.sp, regs.acc, regs.idx_lo},
			{1'b1, 16'h01FF, 8'hC3, 16'h01FE, 8'h2C, 8'h07}, "push");
		issue(CRF_OP_PULL, CRF_ALU_PASS, 16'h0000);
		chk({mem_rd, mem_addr, regs.sp}, {1'b1, 16'h01FF, 16'h01FF}, "pull");
		issue(CRF_OP_LDA, CRF_ALU_PASS, {8'h00, rd_data});
		chk(regs.acc, 8'hC3, "pulled byte");
		issue(CRF_OP_NOP, CRF_ALU_PASS, 16'h0005, CRF_AD_IDX);
		chk({mem_rd, mem_addr}, {1'b1, 16'h0407}, "indexed address");
		issue(CRF_OP_NOP, CRF_ALU_PASS, 16'h1280, CRF_AD_DIR);
		chk({mem_rd, mem_addr}, {1'b1, 16'h0080}, "direct address");
		issue(CRF_OP_JUMP, CRF_ALU_PASS, 16'h2000);
		issue(CRF_OP_BRANCH, CRF_ALU_PASS, 16'h00F0);
		chk(regs.pc, 16'h1FF0, "branch back");
		issue(CRF_OP_BRANCH, CRF_ALU_PASS, 16'h0020);
		chk(regs.pc, 16'h2010, "branch forward");
		issue(CRF_OP_NOP, CRF_ALU_PASS, 16'h0000);
		do_reset();
		chk({regs.acc, regs.idx_hi, regs.idx_lo, regs.sp}, 40'hC3000700FF, "second reset");
		chk(regs.pc, VEC, "second vector");
		issue(CRF_OP_LDHX, CRF_ALU_PASS, 16'h0100);
		issue(CRF_OP_DIV, CRF_ALU_PASS, 16'h0000);
		chk({div_error, regs.acc, regs.idx_hi}, {1'b1, 8'hC3, 8'h01}, "divide by zero");
		issue(CRF_OP_LDA, CRF_ALU_PASS, 16'h0088);
		issue(CRF_OP_ALU_A, CRF_ALU_ADD, 16'h0088);
		chk({regs.acc, regs.ccr}, 16'h10F9, "add flags");
		issue(CRF_OP_LDCC, CRF_ALU_PASS, 16'h0000);
		chk(regs.ccr, 8'h60, "ccr load");
		issue(CRF_OP_ALU_A, CRF_ALU_SUB, 16'h0020);
		chk({regs.acc, regs.ccr}, 16'hF065, "sub flags");
		issue(CRF_OP_NOP, CRF_ALU_PASS, 16'h0010, CRF_AD_IDXO);
		chk({mem_rd, mem_addr}, {1'b1, 16'h0110}, "indexed offset address");
		issue(CRF_OP_NOP, CRF_ALU_PASS, 16'hC234, CRF_AD_EXT);
		chk({mem_rd, mem_addr}, {1'b1, 16'hC234}, "extended address");
		issue(CRF_OP_LDHX, CRF_ALU_PASS, 16'h0003);
		issue(CRF_OP_DIV, CRF_ALU_PASS, 16'h0000);
		chk({div_error, regs.acc, regs.idx_hi}, {1'b0, 8'h50, 8'h00}, "divide after error");
		conclude();
	end
endmodule
